/* haem_consts.svh */
// Purpose: constants for the home agent event monitor
// Assumes: event codes and sub-event mask bits as seen by software
// Notes:   included by the package, the selector and the monitor
//
// How it works
// - Code 0x06 adds one per tracker pool allocation, at most one per cycle.
// - Tracker mask 0x03 counts local and remote requests together, no read/write split.
// - Tracker entry allocated on request arrival, freed after snoop, data and ring reply.
// - Code 0x0f counts address ring sends; bit0 completions, bit1 snoops.
// - Snoop sub-event stays zero while early-snoop mode is active.
// - Code 0x2a counts address egress full cycles per scheduler bank mask.
// - Code 0x32 counts acknowledge egress full cycles, same bank mask.
// - Code 0x36 counts data egress full cycles, bank 0, bank 1 or both.
// - Code 0x0e counts local completions on acknowledge ring, one per cycle.
// - Code 0x10 counts data ring responses; bit0 cache, bit1 core, bit2 remote.
// - Code 0x18 counts cycles without regular write credits, up to 4 per cycle.
// - A write to the memory controller needs a held write queue credit.
// - Credits split regular and special; starvation looks at regular only.
// - Starvation mask bits 0 to 3 each pick one channel, any combination.
`ifndef HAEM_CONSTS_SVH
`define HAEM_CONSTS_SVH
`define HAEM_EV_TRACKER     8'h06
`define HAEM_EV_ACK_NDC     8'h0e
`define HAEM_EV_ADDR_OUT    8'h0f
`define HAEM_EV_DATA_OUT    8'h10
`define HAEM_EV_WR_STARVE   8'h18
`define HAEM_EV_ADDR_FULL   8'h2a
`define HAEM_EV_ACK_FULL    8'h32
`define HAEM_EV_DATA_FULL   8'h36
`define HAEM_TRACKER_ALL    8'h03
`define HAEM_BIT0           0
`define HAEM_BIT1           1
`define HAEM_BIT2           2
`define HAEM_NUM_CTR        4
`define HAEM_NUM_CHAN       4
`define HAEM_CTR_W          48
`define HAEM_CTR_RST        48'h0
`endif

/* haem_pkg.sv */
// Purpose: shared types for the home agent event monitor
// Assumes: constants header sits beside this file
// Notes:   types only
`include "haem_consts.svh"
package haem_pkg;
  typedef logic [7:0] haem_code_t;
  typedef logic [7:0] haem_mask_t;
  typedef logic [2:0] haem_inc_t;
  typedef logic [`HAEM_CTR_W-1:0] haem_count_t;
endpackage

/* haem_selector.sv */
// Purpose: one counter's event selection and accumulation
// Assumes: event inputs are single-cycle qualified levels
// Notes:   counter wraps at its width
`timescale 1ns/1ps
`default_nettype none
`include "haem_consts.svh"
module haem_selector #(
  parameter int CTR_W = `HAEM_CTR_W
) (
  input  wire logic                   clk,
  input  wire logic                   reset_n,
  input  wire logic                   enable,
  input  wire logic                   clear,
  input  wire haem_pkg::haem_code_t   event_code,
  input  wire haem_pkg::haem_mask_t   sub_mask,
  input  wire logic                   tracker_alloc_event,
  input  wire logic                   addr_ndc_event,
  input  wire logic                   addr_snoop_event,
  input  wire logic [1:0]             addr_egress_full_event,
  input  wire logic [1:0]             ack_egress_full_event,
  input  wire logic [1:0]             data_egress_full_event,
  input  wire logic                   ack_ring_completion_event,
  input  wire logic [2:0]             data_ring_out_event,
  input  wire logic [3:0]             write_credit_starve_event,
  output logic [CTR_W-1:0]            count
);
  haem_pkg::haem_inc_t inc;
  logic [CTR_W-1:0]    next_count;

  // per-cycle increment from the chosen event and its masked sub-events
  always_comb begin
    inc = 3'h0;
    unique case (event_code)
      `HAEM_EV_TRACKER:
        inc = {2'h0, tracker_alloc_event
               & (sub_mask == `HAEM_TRACKER_ALL)};
      `HAEM_EV_ADDR_OUT:
        inc = {2'h0, addr_ndc_event & sub_mask[`HAEM_BIT0]}
            + {2'h0, addr_snoop_event & sub_mask[`HAEM_BIT1]};
      `HAEM_EV_ADDR_FULL:
        inc = {2'h0, |(addr_egress_full_event & sub_mask[1:0])};
      `HAEM_EV_ACK_FULL:
        inc = {2'h0, |(ack_egress_full_event & sub_mask[1:0])};
      `HAEM_EV_DATA_FULL:
        inc = {2'h0, |(data_egress_full_event & sub_mask[1:0])};
      `HAEM_EV_ACK_NDC:
        inc = {2'h0, ack_ring_completion_event};
      `HAEM_EV_DATA_OUT:
        inc = {2'h0, data_ring_out_event[0] & sub_mask[`HAEM_BIT0]}
            + {2'h0, data_ring_out_event[1] & sub_mask[`HAEM_BIT1]}
            + {2'h0, data_ring_out_event[2] & sub_mask[`HAEM_BIT2]};
      `HAEM_EV_WR_STARVE:
        inc = {2'h0, write_credit_starve_event[0] & sub_mask[0]}
            + {2'h0, write_credit_starve_event[1] & sub_mask[1]}
            + {2'h0, write_credit_starve_event[2] & sub_mask[2]}
            + {2'h0, write_credit_starve_event[3] & sub_mask[3]};
      default:
        inc = 3'h0;
    endcase
  end

  // accumulate, clear has priority
  always_comb begin
    if (clear) begin
      next_count = '0;
    end else if (enable) begin
      next_count = count + {{(CTR_W-3){1'b0}}, inc};
    end else begin
      next_count = count;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      count <= `HAEM_CTR_RST;
    end else begin
      count <= next_count;
    end
  end
endmodule // haem_selector
`default_nettype wire

/* haem_monitor.sv */
// Purpose: home agent event monitor with tracker pool and write credits
// Assumes: one uncore clock, synchronous inputs
// Notes:   four independent counters share the raw event lines
`timescale 1ns/1ps
`default_nettype none
`include "haem_consts.svh"
module haem_monitor #(
  parameter int NUM_TRK  = 8,
  parameter int TRK_W    = 3,
  parameter int REG_CRED = 8,
  parameter int SPC_CRED = 2,
  parameter int CRED_W   = 4,
  parameter int CTR_W    = `HAEM_CTR_W
) (
  input  wire logic                      clk,
  input  wire logic                      reset_n,
  // counter configuration, one lane per counter except the shared early_snoop_mode
  input  wire logic [`HAEM_NUM_CTR-1:0]  ctr_enable,
  input  wire logic [`HAEM_NUM_CTR-1:0]  ctr_clear,
  input  wire logic [31:0]               ctr_event_code,
  input  wire logic [31:0]               ctr_sub_mask,
  input  wire logic                      early_snoop_mode,
  // tracker request side
  input  wire logic                      req_arrive,
  input  wire logic                      req_remote,
  input  wire logic                      req_is_write,
  output logic                           req_ready,
  output logic [TRK_W-1:0]               alloc_index,
  input  wire logic                      snoop_done,
  input  wire logic                      data_done,
  input  wire logic                      reply_on_ring,
  input  wire logic [TRK_W-1:0]          done_index,
  output logic [NUM_TRK-1:0]             tracker_busy,
  // ring activity
  input  wire logic                      addr_ndc_sent,
  input  wire logic                      addr_snoop_sent,
  input  wire logic [1:0]                addr_bank_full,
  input  wire logic [1:0]                ack_bank_full,
  input  wire logic [1:0]                data_bank_full,
  input  wire logic                      ack_completion_sent,
  input  wire logic [2:0]                data_resp_sent,
  // write credits per memory channel
  input  wire logic [`HAEM_NUM_CHAN-1:0] wr_req,
  input  wire logic [`HAEM_NUM_CHAN-1:0] wr_special,
  input  wire logic [`HAEM_NUM_CHAN-1:0] cred_return,
  input  wire logic [`HAEM_NUM_CHAN-1:0] cred_return_special,
  output logic [`HAEM_NUM_CHAN-1:0]      wr_issue,
  // counters
  output logic [4*CTR_W-1:0]             counts
);
  // tracker pool state
  logic [NUM_TRK-1:0] busy;
  logic [NUM_TRK-1:0] snp_ok;
  logic [NUM_TRK-1:0] dat_ok;
  logic [NUM_TRK-1:0] next_busy;
  logic [NUM_TRK-1:0] next_snp_ok;
  logic [NUM_TRK-1:0] next_dat_ok;
  logic               free_found;
  logic [TRK_W-1:0]   free_idx;
  logic               alloc_now;
  logic               trk_event;
  logic               next_trk_event;

  // find lowest free entry
  always_comb begin
    free_found = 1'b0;
    free_idx   = '0;
    for (int i = NUM_TRK-1; i >= 0; i--) begin
      if (!busy[i]) begin
        free_found = 1'b1;
        free_idx   = TRK_W'(i);
      end
    end
  end

  assign req_ready    = free_found;
  assign alloc_now    = req_arrive & free_found;
  assign tracker_busy = busy;

  // allocate on arrival, free once snoop, data and reply all done
  always_comb begin
    next_busy      = busy;
    next_snp_ok    = snp_ok;
    next_dat_ok    = dat_ok;
    next_trk_event = alloc_now;
    if (busy[done_index]) begin
      if (snoop_done) begin
        next_snp_ok[done_index] = 1'b1;
      end
      if (data_done) begin
        next_dat_ok[done_index] = 1'b1;
      end
      if (reply_on_ring && (snp_ok[done_index] || snoop_done)
          && (dat_ok[done_index] || data_done)) begin
        next_busy[done_index]   = 1'b0;
        next_snp_ok[done_index] = 1'b0;
        next_dat_ok[done_index] = 1'b0;
      end
    end
    if (alloc_now) begin
      next_busy[free_idx]   = 1'b1;
      next_snp_ok[free_idx] = 1'b0;
      next_dat_ok[free_idx] = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      busy        <= '0;
      snp_ok      <= '0;
      dat_ok      <= '0;
      trk_event   <= 1'b0;
      alloc_index <= '0;
    end else begin
      busy        <= next_busy;
      snp_ok      <= next_snp_ok;
      dat_ok      <= next_dat_ok;
      trk_event   <= next_trk_event;
      alloc_index <= alloc_now ? free_idx : alloc_index;
    end
  end

  // write credits: regular and special pools per channel
  logic [CRED_W-1:0] reg_cred [`HAEM_NUM_CHAN];
  logic [CRED_W-1:0] spc_cred [`HAEM_NUM_CHAN];
  logic [CRED_W-1:0] next_reg_cred [`HAEM_NUM_CHAN];
  logic [CRED_W-1:0] next_spc_cred [`HAEM_NUM_CHAN];
  logic [`HAEM_NUM_CHAN-1:0] starve;
  logic [`HAEM_NUM_CHAN-1:0] next_wr_issue;

  genvar ch;
  generate
    for (ch = 0; ch < `HAEM_NUM_CHAN; ch++) begin : g_chan
      logic use_reg;
      logic use_spc;

      // issue only with a held credit of the right pool
      assign use_reg = wr_req[ch] & ~wr_special[ch]
                     & (reg_cred[ch] != '0);
      assign use_spc = wr_req[ch] & wr_special[ch]
                     & (spc_cred[ch] != '0);
      assign starve[ch] = (reg_cred[ch] == '0);

      always_comb begin
        next_reg_cred[ch] = reg_cred[ch]
                          - CRED_W'(use_reg) + CRED_W'(cred_return[ch]);
        next_spc_cred[ch] = spc_cred[ch] - CRED_W'(use_spc)
                          + CRED_W'(cred_return_special[ch]);
        next_wr_issue[ch] = use_reg | use_spc;
      end

      always_ff @(posedge clk) begin
        if (!reset_n) begin
          reg_cred[ch] <= CRED_W'(REG_CRED);
          spc_cred[ch] <= CRED_W'(SPC_CRED);
        end else begin
          reg_cred[ch] <= next_reg_cred[ch];
          spc_cred[ch] <= next_spc_cred[ch];
        end
      end
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      wr_issue <= '0;
    end else begin
      wr_issue <= next_wr_issue;
    end
  end

  // snoop sub-event gated off in early-snoop mode
  logic snoop_counted;
  assign snoop_counted = addr_snoop_sent & ~early_snoop_mode;

  // four independent counters
  genvar c;
  generate
    for (c = 0; c < `HAEM_NUM_CTR; c++) begin : g_ctr
      haem_selector #(
        .CTR_W(CTR_W)
      ) u_sel (
        .clk                       (clk),
        .reset_n                   (reset_n),
        .enable                    (ctr_enable[c]),
        .clear                     (ctr_clear[c]),
        .event_code                (ctr_event_code[8*c +: 8]),
        .sub_mask                  (ctr_sub_mask[8*c +: 8]),
        .tracker_alloc_event       (trk_event),
        .addr_ndc_event            (addr_ndc_sent),
        .addr_snoop_event          (snoop_counted),
        .addr_egress_full_event    (addr_bank_full),
        .ack_egress_full_event     (ack_bank_full),
        .data_egress_full_event    (data_bank_full),
        .ack_ring_completion_event (ack_completion_sent),
        .data_ring_out_event       (data_resp_sent),
        .write_credit_starve_event (starve),
        .count                     (counts[CTR_W*c +: CTR_W])
      );
    end
  endgenerate
endmodule // haem_monitor
`default_nettype wire

/* haem_monitor_properties.sv */
// Purpose: port-level checks of the event monitor, counter lanes 0 to 2
// Assumes: one clock, synchronous active-low reset
// Notes:   bound to haem_monitor from the testbench top file
`timescale 1ns/1ps
`default_nettype none
module haem_monitor_properties #(
  parameter int NUM_TRK = 8,
  parameter int TRK_W   = 3,
  parameter int CTR_W   = 48
) (
  input wire logic               clk,
  input wire logic               reset_n,
  input wire logic [3:0]         ctr_enable,
  input wire logic [3:0]         ctr_clear,
  input wire logic [31:0]        ctr_event_code,
  input wire logic [31:0]        ctr_sub_mask,
  input wire logic               early_snoop_mode,
  input wire logic               req_arrive,
  input wire logic               req_ready,
  input wire logic [NUM_TRK-1:0] tracker_busy,
  input wire logic               addr_ndc_sent,
  input wire logic               addr_snoop_sent,
  input wire logic [1:0]         addr_bank_full,
  input wire logic [1:0]         ack_bank_full,
  input wire logic [1:0]         data_bank_full,
  input wire logic               ack_completion_sent,
  input wire logic [2:0]         data_resp_sent,
  input wire logic [3:0]         wr_req,
  input wire logic [3:0]         wr_issue,
  input wire logic [4*CTR_W-1:0] counts
);
  logic [3:0]            on;
  logic [3:0][7:0]       cd;
  logic [3:0][7:0]       mk;
  logic [3:0][CTR_W-1:0] cn;
  // per-lane selection and count, each check on the lane that sees it
  assign on = ctr_enable & ~ctr_clear;
  assign cd = ctr_event_code;
  assign mk = ctr_sub_mask;
  assign cn = counts;
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  a_snoop_mute: assert property (
    on[0] && cd[0] == 8'h0f && mk[0][1:0] == 2'h2 && early_snoop_mode
    |=> cn[0] == $past(cn[0])) else $error("snoop counted in early mode");
  a_addr_sum: assert property (
    on[1] && cd[1] == 8'h0f && mk[1][1:0] == 2'h3 && !early_snoop_mode &&
    addr_ndc_sent && addr_snoop_sent |=> cn[1] == $past(cn[1]) + 48'd2)
    else $error("address ring sum wrong");
  a_addr_full_any: assert property (
    on[1] && cd[1] == 8'h2a && mk[1][1:0] == 2'h3 && addr_bank_full != 2'h0
    |=> cn[1] == $past(cn[1]) + 48'd1)
    else $error("address full not counted");
  a_ack_full_bank: assert property (
    on[2] && cd[2] == 8'h32 && mk[2][1:0] == 2'h1
    |=> cn[2] == $past(cn[2]) + $past(ack_bank_full[0]))
    else $error("ack egress bank 0 count wrong");
  a_data_full_bank: assert property (
    on[0] && cd[0] == 8'h36 && mk[0][1:0] == 2'h2
    |=> cn[0] == $past(cn[0]) + $past(data_bank_full[1]))
    else $error("data egress bank 1 count wrong");
  a_ack_done: assert property (
    on[1] && cd[1] == 8'h0e
    |=> cn[1] == $past(cn[1]) + $past(ack_completion_sent))
    else $error("ack completion count wrong");
  a_data_resp: assert property (
    on[2] && cd[2] == 8'h10 && mk[2][2:0] == 3'h7
    |=> cn[2] == $past(cn[2]) + $countones($past(data_resp_sent)))
    else $error("data response sum wrong");
  a_one_channel: assert property (
    on[2] && cd[2] == 8'h18 && mk[2] == 8'h08
    |=> cn[2] - $past(cn[2]) <= 48'd1)
    else $error("one channel added more than one");
  a_issue_needs_req: assert property (
    wr_issue[0] |-> $past(wr_req[0])) else $error("write without request");
  a_alloc_busy: assert property (
    req_arrive && req_ready |=> tracker_busy != '0)
    else $error("taken request left tracker empty");
  // main scenarios reached
  c_trk_full: cover property (tracker_busy == '1);
  c_starve_four: cover property (on[0] && cd[0] == 8'h18 && mk[0] == 8'h0f
    ##1 cn[0] == $past(cn[0]) + 48'd4);
  c_snoop_mute: cover property (on[0] && cd[0] == 8'h0f && early_snoop_mode);
endmodule // haem_monitor_properties
`default_nettype wire

/* haem_far_side.sv */
// Purpose: credit return side of the memory write queue
// Assumes: one credit back per channel and pool per cycle
// Notes:   hold stalls all returns to model a slow controller
`timescale 1ns/1ps
`default_nettype none
module haem_far_side (
  input  wire logic       clk,
  input  wire logic       reset_n,
  input  wire logic       hold,
  input  wire logic [3:0] wr_issue,
  input  wire logic [3:0] wr_special,
  output logic      [3:0] cred_return,
  output logic      [3:0] cred_return_special
);
  int         owed_r [4];
  int         owed_s [4];
  logic [3:0] sp_q;
  logic       go;
  assign go = reset_n & ~hold;
  // return only credits of writes issued earlier, pool by pool
  always_ff @(posedge clk) begin
    sp_q <= wr_special;
    for (int c = 0; c < 4; c++) begin
      cred_return[c]         <= go && owed_r[c] != 0;
      cred_return_special[c] <= go && owed_s[c] != 0;
      owed_r[c] <= !reset_n ? 0 : owed_r[c]
        + int'(wr_issue[c] & ~sp_q[c]) - int'(go && owed_r[c] != 0);
      owed_s[c] <= !reset_n ? 0 : owed_s[c]
        + int'(wr_issue[c] & sp_q[c]) - int'(go && owed_s[c] != 0);
    end
  end
endmodule // haem_far_side
`default_nettype wire

/* tb.sv */
// Purpose: self-checking bench of the home agent event monitor
// Assumes: design defaults NUM_TRK 8, REG_CRED 8, SPC_CRED 2
// Notes:   inputs change 1 ns after the rising edge
`timescale 1ns/1ps
`default_nettype none
bind haem_monitor haem_monitor_properties #(.NUM_TRK(NUM_TRK),
  .TRK_W(TRK_W), .CTR_W(CTR_W)) haem_monitor_properties_i (.*);
module tb;
  logic clk = 1'b0, reset_n, early_snoop_mode, hold, req_arrive, req_ready;
  logic req_remote, req_is_write, snoop_done, data_done, reply_on_ring;
  logic addr_ndc_sent, addr_snoop_sent, ack_completion_sent;
  logic [3:0] ctr_enable, ctr_clear, wr_req, wr_special, wr_issue;
  logic [3:0] cred_return, cred_return_special;
  logic [31:0] ctr_event_code, ctr_sub_mask;
  logic [2:0] alloc_index, done_index, data_resp_sent;
  logic [1:0] addr_bank_full, ack_bank_full, data_bank_full;
  logic [7:0] tracker_busy;
  logic [191:0] counts;
  int n_mismatch = 0, samples_checked = 0, cyc = 0, n_iss = 0;
  // code, mask, increment per enabled cycle; last row with early snoop
  logic [19:0] tab [20] = '{20'h0f011, 20'h0f032, 20'h0f021, 20'h2a010,
    20'h2a021, 20'h2a031, 20'h32011, 20'h32020, 20'h36020, 20'h0e001,
    20'h10072, 20'h10020, 20'h10041, 20'h06030, 20'h55ff0, 20'h180f0,
    20'h0f020, 20'h0f031, 20'h0eff1, 20'h36031};
  haem_monitor haem_monitor_i (.*);
  haem_far_side haem_far_side_i (.*);
  always #4 clk = ~clk;
  // cycle ceiling and issued-write tally
  always @(posedge clk) begin
    cyc <= cyc + 1;
    n_iss <= n_iss + $countones(wr_issue);
    if (cyc == 2000) begin
      n_mismatch++;
      results();
    end
  end
  task automatic step(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk(logic [47:0] seen, logic [47:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic cfg(int c, logic [7:0] cd, logic [7:0] mk);
    ctr_event_code[8*c +: 8] = cd;
    ctr_sub_mask[8*c +: 8] = mk;
  endtask
  task automatic zap();
    ctr_clear = 4'hf;
    step(1);
    ctr_clear = 4'h0;
  endtask
  function automatic logic [47:0] lane(int c);
    return counts[48*c +: 48];
  endfunction
  task automatic results();
    if (n_mismatch == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // main sequence
  initial begin
    {reset_n, early_snoop_mode, req_arrive, req_remote, req_is_write} = '0;
    {snoop_done, data_done, reply_on_ring, done_index, ctr_enable} = '0;
    {ctr_clear, wr_req, wr_special, ctr_event_code, ctr_sub_mask} = '0;
    {addr_ndc_sent, addr_snoop_sent, ack_completion_sent} = 3'h7;
    {addr_bank_full, ack_bank_full, data_bank_full} = 6'h25;
    data_resp_sent = 3'h5;
    hold = 1'b1;
    step(3);
    reset_n = 1'b1;
    chk(tracker_busy, 0);
    chk(req_ready, 1);
    for (int g = 0; g < 5; g++) begin
      early_snoop_mode = (g == 4);
      for (int c = 0; c < 4; c++)
        cfg(c, tab[4*g+c][19:12], tab[4*g+c][11:4]);
      zap();
      ctr_enable = 4'hf;
      step(5);
      ctr_enable = 4'h0;
      step(1);
      for (int c = 0; c < 4; c++)
        chk(lane(c), 5 * tab[4*g+c][3:0]);
    end
    zap();
    cfg(0, 8'h06, 8'h03);
    cfg(1, 8'h06, 8'h01);
    ctr_enable = 4'h3;
    req_arrive = 1'b1;
    step(10);
    req_arrive = 1'b0;
    step(3);
    chk(lane(0), 8);
    chk(lane(1), 0);
    chk(tracker_busy, 8'hff);
    chk(req_ready, 0);
    reply_on_ring = 1'b1;
    step(1);
    reply_on_ring = 1'b0;
    step(1);
    chk(tracker_busy, 8'hff);
    {snoop_done, data_done, reply_on_ring} = 3'h7;
    step(1);
    {snoop_done, data_done, reply_on_ring} = 3'h0;
    step(1);
    chk(tracker_busy, 8'hfe);
    {req_arrive, req_remote} = 2'h3;
    step(1);
    req_arrive = 1'b0;
    step(3);
    chk(lane(0), 9);
    chk(alloc_index, 0);
    zap();
    cfg(0, 8'h18, 8'h0f);
    cfg(1, 8'h18, 8'h05);
    cfg(2, 8'h18, 8'h08);
    ctr_enable = 4'h0;
    wr_req = 4'hf;
    step(12);
    chk(n_iss, 32);
    ctr_enable = 4'h7;
    step(6);
    ctr_enable = 4'h0;
    step(1);
    chk(lane(0), 24);
    chk(lane(1), 12);
    chk(lane(2), 6);
    {wr_special, ctr_enable} = 8'hf1;
    step(4);
    {wr_req, wr_special, ctr_enable} = 12'h0;
    step(2);
    chk(n_iss, 40);
    chk(lane(0), 40);
    hold = 1'b0;
    step(20);
    ctr_enable = 4'h1;
    step(5);
    ctr_enable = 4'h0;
    step(1);
    chk(lane(0), 40);
    results();
  end
endmodule // tb
`default_nettype wire
